/* design/rct16_timer.sv */
/*
  Reloadable compare timer: 16-bit up counter with prescaler, auto-reload
  and compare modes, three capture result registers and an Avalon-MM
  slave with waitrequest for its byte-wide registers.
  Assumes capture events arrive as one-cycle pulses already filtered and
  edge detected, synchronous to clock.
*/
// Register access over Avalon-MM is this design's own decision.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "rct16_params.svh"

module rct16_timer
    import rct16_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic [`RCT_ADDR_W-1:0]    avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [`RCT_DATA_W-1:0]    avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [`RCT_DATA_W-1:0]    avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [`RCT_CHANNELS-1:0]  capture_event,
    output logic                           timer_irq
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic                      timer_event_flag_r;
    logic                      run_control_r;
    rct_mode_t                 compare_reload_select_r;
    logic                      reload_enable_r;
    logic [2:0]                prescale_select_r;
    logic                      capture_clear_enable_r;
    logic                      match_clear_enable_r;
    rct_trig_t                 reload_trigger_select_r;
    logic [7:0]                reload_compare_low_r;
    logic [7:0]                reload_compare_high_r;
    logic [15:0]               count_r;
    logic [15:0]               count_nxt;
    logic                      timer_irq_enable_r;
    logic                      global_irq_enable_r;
    logic [`RCT_CHANNELS-1:0]  capture_enable_r;
    logic [`RCT_CHANNELS-1:0]  capture_channel_flag_r;
    logic [15:0]               capture_result_r [`RCT_CHANNELS];
    logic [`RCT_PRE_W-1:0]     prescale_cnt_r;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic [7:0] reg_index;
    logic       wr_take;
    logic       lane0;
    logic [7:0] wbyte;

    assign reg_index = avs_address[`RCT_ADDR_W-1:2];
    // Write lands at the edge where waitrequest is seen low
    assign wr_take   = avs_write && !avs_waitrequest;
    assign lane0     = avs_byteenable[0];
    assign wbyte     = avs_writedata[7:0];

    function automatic logic wr_hit(input logic [7:0] idx);
        wr_hit = wr_take && lane0 && (reg_index == idx);
    endfunction : wr_hit

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    logic [`RCT_PRE_W-1:0] prescale_last;
    logic                  step;

    always_comb begin
        unique case (prescale_select_r)
            3'h0: prescale_last = 9'h000;
            3'h1: prescale_last = 9'h003;
            3'h2: prescale_last = 9'h00f;
            3'h3: prescale_last = 9'h01f;
            3'h4: prescale_last = 9'h03f;
            3'h5: prescale_last = 9'h07f;
            3'h6: prescale_last = 9'h0ff;
            3'h7: prescale_last = 9'h1ff;
        endcase
    end

    // Divider only runs with the timer so a restart begins a full period
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prescale_cnt_r <= '0;
        end else if (!run_control_r) begin
            prescale_cnt_r <= '0;
        end else if (prescale_cnt_r >= prescale_last) begin
            prescale_cnt_r <= '0;
        end else begin
            prescale_cnt_r <= prescale_cnt_r + 9'h001;
        end
    end

    assign step = run_control_r && (prescale_cnt_r >= prescale_last);

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    logic [15:0]              compare_value;
    logic                     overflow;
    logic                     match;
    logic [`RCT_CHANNELS-1:0] cap_hit;
    logic                     any_cap;
    logic                     reload_event;
    logic                     auto_mode;

    assign compare_value = {reload_compare_high_r, reload_compare_low_r};
    assign auto_mode     = (compare_reload_select_r == RCT_MODE_RELOAD);
    assign overflow      = step && (count_r == `RCT_COUNT_MAX);
    assign match         = step && !auto_mode && (count_r == compare_value);
    assign cap_hit       = capture_event & capture_enable_r;
    assign any_cap       = |cap_hit;

    always_comb begin
        unique case (reload_trigger_select_r)
            RCT_TRIG_OVERFLOW: reload_event = overflow;
            RCT_TRIG_CAP0:     reload_event = cap_hit[0];
            RCT_TRIG_CAP1:     reload_event = cap_hit[1];
            RCT_TRIG_CAP2:     reload_event = cap_hit[2];
        endcase
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // A bus write to a count byte wins; software is expected to stop first
    always_comb begin
        count_nxt = count_r;
        if (auto_mode && capture_clear_enable_r && any_cap) begin
            count_nxt = `RCT_RESET_COUNT;
        end else if (auto_mode && reload_enable_r && reload_event) begin
            count_nxt = compare_value;
        end else if (match && match_clear_enable_r) begin
            count_nxt = `RCT_RESET_COUNT;
        end else if (step) begin
            count_nxt = count_r + 16'h0001;
        end
        if (wr_hit(`RCT_IDX_COUNT_LOW)) begin
            count_nxt[7:0] = wbyte;
        end
        if (wr_hit(`RCT_IDX_COUNT_HIGH)) begin
            count_nxt[15:8] = wbyte;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_r <= `RCT_RESET_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Control and mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            run_control_r           <= 1'b0;
            compare_reload_select_r <= RCT_MODE_RELOAD;
        end else if (wr_hit(`RCT_IDX_CONTROL)) begin
            run_control_r           <= wbyte[`RCT_CTL_RUN_BIT];
            compare_reload_select_r <= rct_mode_t'(wbyte[`RCT_CTL_MODE_BIT]);
        end
    end

    // Hardware set has priority over a clearing write
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer_event_flag_r <= 1'b0;
        end else if (overflow || match) begin
            timer_event_flag_r <= 1'b1;
        end else if (wr_hit(`RCT_IDX_CONTROL)) begin
            timer_event_flag_r <= wbyte[`RCT_CTL_FLAG_BIT];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reload_enable_r         <= 1'b0;
            prescale_select_r       <= 3'h0;
            capture_clear_enable_r  <= 1'b0;
            match_clear_enable_r    <= 1'b0;
            reload_trigger_select_r <= RCT_TRIG_OVERFLOW;
        end else if (wr_hit(`RCT_IDX_MODE)) begin
            reload_enable_r         <= wbyte[`RCT_MOD_RELOAD_BIT];
            prescale_select_r       <= wbyte[`RCT_MOD_DIV_HI:`RCT_MOD_DIV_LO];
            capture_clear_enable_r  <= wbyte[`RCT_MOD_CAPCLR_BIT];
            match_clear_enable_r    <= wbyte[`RCT_MOD_CMPCLR_BIT];
            reload_trigger_select_r <=
                rct_trig_t'(wbyte[`RCT_MOD_TRIG_HI:`RCT_MOD_TRIG_LO]);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reload_compare_low_r  <= `RCT_RESET_BYTE;
            reload_compare_high_r <= `RCT_RESET_BYTE;
        end else begin
            if (wr_hit(`RCT_IDX_RCMP_LOW)) begin
                reload_compare_low_r <= wbyte;
            end
            if (wr_hit(`RCT_IDX_RCMP_HIGH)) begin
                reload_compare_high_r <= wbyte;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer_irq_enable_r  <= 1'b0;
            global_irq_enable_r <= 1'b0;
        end else if (wr_hit(`RCT_IDX_IRQ_ENABLE)) begin
            timer_irq_enable_r  <= wbyte[`RCT_IEN_TIMER_BIT];
            global_irq_enable_r <= wbyte[`RCT_IEN_GLOBAL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Capture channels
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            capture_enable_r <= '0;
        end else if (wr_hit(`RCT_IDX_CAP_CONTROL)) begin
            capture_enable_r <= wbyte[`RCT_CAP_EN_LO +: `RCT_CHANNELS];
        end
    end

    // Result holds the count from before any clear or reload that same edge
    for (genvar ch = 0; ch < `RCT_CHANNELS; ch++) begin : g_cap
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                capture_result_r[ch] <= `RCT_RESET_COUNT;
            end else if (cap_hit[ch]) begin
                capture_result_r[ch] <= count_r;
            end
        end

        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                capture_channel_flag_r[ch] <= 1'b0;
            end else if (cap_hit[ch]) begin
                capture_channel_flag_r[ch] <= 1'b1;
            end else if (wr_hit(`RCT_IDX_CAP_CONTROL)) begin
                capture_channel_flag_r[ch] <= wbyte[`RCT_CAP_FLAG_LO + ch];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_event_flag_r && timer_irq_enable_r
                         && global_irq_enable_r;
        end
    end

    // ----------------------------------------------------------------
    // Bus read and handshake
    // ----------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_index)
            `RCT_IDX_CONTROL:
                rd_byte = {timer_event_flag_r, 4'h0, run_control_r, 1'b0,
                           compare_reload_select_r};
            `RCT_IDX_MODE:
                rd_byte = {reload_enable_r, prescale_select_r,
                           capture_clear_enable_r, match_clear_enable_r,
                           reload_trigger_select_r};
            `RCT_IDX_RCMP_LOW:    rd_byte = reload_compare_low_r;
            `RCT_IDX_RCMP_HIGH:   rd_byte = reload_compare_high_r;
            `RCT_IDX_COUNT_LOW:   rd_byte = count_r[7:0];
            `RCT_IDX_COUNT_HIGH:  rd_byte = count_r[15:8];
            `RCT_IDX_IRQ_ENABLE:
                rd_byte = {6'h00, global_irq_enable_r, timer_irq_enable_r};
            `RCT_IDX_CAP_CONTROL:
                rd_byte = {1'b0, capture_enable_r, 1'b0, capture_channel_flag_r};
            `RCT_IDX_CAP_BASE:          rd_byte = capture_result_r[0][7:0];
            `RCT_IDX_CAP_BASE + 8'h01:  rd_byte = capture_result_r[0][15:8];
            `RCT_IDX_CAP_BASE + 8'h02:  rd_byte = capture_result_r[1][7:0];
            `RCT_IDX_CAP_BASE + 8'h03:  rd_byte = capture_result_r[1][15:8];
            `RCT_IDX_CAP_BASE + 8'h04:  rd_byte = capture_result_r[2][7:0];
            `RCT_IDX_CAP_BASE + 8'h05:  rd_byte = capture_result_r[2][15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    // One wait cycle per access: waitrequest drops for exactly one edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    // Read data sampled one cycle early so it stands at the completing edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h000000, rd_byte};
        end
    end

endmodule : rct16_timer

/* design/rct16_params.svh */
/*
  Constants of the reloadable compare timer: register indices, field
  positions, reset values and bus widths.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef RCT16_PARAMS_SVH
`define RCT16_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RCT_IDX_CONTROL      8'hc8
`define RCT_IDX_MODE         8'hc9
`define RCT_IDX_RCMP_LOW     8'hca
`define RCT_IDX_RCMP_HIGH    8'hcb
`define RCT_IDX_COUNT_LOW    8'hcc
`define RCT_IDX_COUNT_HIGH   8'hcd
`define RCT_IDX_IRQ_ENABLE   8'hd0
`define RCT_IDX_CAP_CONTROL  8'hd1
`define RCT_IDX_CAP_BASE     8'he4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCT_CTL_FLAG_BIT     7
`define RCT_CTL_RUN_BIT      2
`define RCT_CTL_MODE_BIT     0
`define RCT_MOD_RELOAD_BIT   7
`define RCT_MOD_DIV_HI       6
`define RCT_MOD_DIV_LO       4
`define RCT_MOD_CAPCLR_BIT   3
`define RCT_MOD_CMPCLR_BIT   2
`define RCT_MOD_TRIG_HI      1
`define RCT_MOD_TRIG_LO      0
`define RCT_IEN_TIMER_BIT    0
`define RCT_IEN_GLOBAL_BIT   1
`define RCT_CAP_EN_LO        4
`define RCT_CAP_FLAG_LO      0

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define RCT_RESET_BYTE       8'h00
`define RCT_RESET_COUNT      16'h0000
`define RCT_COUNT_MAX        16'hffff
`define RCT_ADDR_W           10
`define RCT_DATA_W           32
`define RCT_PRE_W            9
`define RCT_CHANNELS         3

`endif

/* design/rct16_pkg.sv */
/*
  Types shared by the reloadable compare timer.
  Assumes rct16_params.svh is available on the include path.
*/
package rct16_pkg;

    typedef enum logic {
        RCT_MODE_RELOAD  = 1'b0,
        RCT_MODE_COMPARE = 1'b1
    } rct_mode_t;

    typedef enum logic [1:0] {
        RCT_TRIG_OVERFLOW = 2'h0,
        RCT_TRIG_CAP0     = 2'h1,
        RCT_TRIG_CAP1     = 2'h2,
        RCT_TRIG_CAP2     = 2'h3
    } rct_trig_t;

endpackage : rct16_pkg

/* sim/rct16_timer_monitor.sv */
/*
  Checker for the reloadable compare timer: register bus handshake,
  read data and interrupt request behaviour seen at the top ports.
  Assumes one clock domain and is attached by the bind at the foot.
*/
`timescale 1ns/1ps
`include "rct16_params.svh"

module rct16_timer_monitor (
    input wire logic                      clock,
    input wire logic                      reset,
    input wire logic [`RCT_ADDR_W-1:0]    avs_address,
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [`RCT_DATA_W-1:0]    avs_writedata,
    input wire logic [3:0]                avs_byteenable,
    input wire logic [`RCT_DATA_W-1:0]    avs_readdata,
    input wire logic                      avs_waitrequest,
    input wire logic [`RCT_CHANNELS-1:0]  capture_event,
    input wire logic                      timer_irq
);
    logic [7:0] idx;
    logic       mapped;
    logic       wr_done;
    logic       irq_wr;

    assign idx     = avs_address[9:2];
    assign mapped  = (idx >= 8'hc8 && idx <= 8'hcd) || idx == 8'hd0 || idx == 8'hd1 ||
                     (idx >= 8'he4 && idx <= 8'he9);
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign irq_wr  = wr_done && (idx == 8'hc8 || idx == 8'hd0);

    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_req_answered: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered one cycle after it was taken");
    a_wait_one_cycle: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_no_ack: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_upper_data_zero: assert property (
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    a_unmapped_zero: assert property (
        avs_read && avs_waitrequest && !mapped |=> avs_readdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_rdata_cause: assert property (
        $changed(avs_readdata) |-> $past(avs_read) && !avs_waitrequest)
        else $error("read data changed without a read");
    a_irq_disable: assert property (
        wr_done && idx == 8'hd0 && avs_writedata[1:0] != 2'b11 |=> ##1 !timer_irq)
        else $error("interrupt request stayed up after enables were cleared");
    a_irq_sticky: assert property (
        $fell(timer_irq) |-> $past(irq_wr, 2))
        else $error("interrupt request dropped without a register write");
    a_reset_quiet: assert property (
        $fell(reset) |-> avs_waitrequest && !timer_irq && avs_readdata == 32'h0)
        else $error("outputs not at reset values after reset");

    c_read_done:  cover property (avs_read && !avs_waitrequest);
    c_write_done: cover property (avs_write && !avs_waitrequest);
    c_irq_rise:   cover property ($rose(timer_irq));
endmodule : rct16_timer_monitor

bind rct16_timer rct16_timer_monitor i_rct16_timer_monitor (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_event(capture_event), .timer_irq(timer_irq)
);

/* sim/rct16_cap_src.sv */
/*
  Model of the capture front end: turns each rising request into one
  edge-detected event pulse per channel, with no filtering.
  Assumes requests are synchronous to clock.
*/
`timescale 1ns/1ps

module rct16_cap_src (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [2:0] fire,
    output logic      [2:0] capture_event
);
    logic [2:0] fire_q_r;

    // One cycle per event, since the timer captures on every high cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fire_q_r      <= 3'h0;
            capture_event <= 3'h0;
        end else begin
            fire_q_r      <= fire;
            capture_event <= fire & ~fire_q_r;
        end
    end
endmodule : rct16_cap_src

/* sim/rct16_timer_tb.sv */
/*
  Self-checking bench for the reloadable compare timer.
  Assumes the design, package and parameter header are compiled first.
*/
`timescale 1ns/1ps
`include "rct16_params.svh"

module rct16_timer_tb;
    import rct16_pkg::*;
    localparam logic [7:0] CTL = `RCT_IDX_CONTROL, MD = `RCT_IDX_MODE, CB = `RCT_IDX_CAP_BASE;
    localparam logic [7:0] RL = `RCT_IDX_RCMP_LOW, RH = `RCT_IDX_RCMP_HIGH;
    localparam logic [7:0] CL = `RCT_IDX_COUNT_LOW, CH = `RCT_IDX_COUNT_HIGH;
    localparam logic [7:0] IE = `RCT_IDX_IRQ_ENABLE, CC = `RCT_IDX_CAP_CONTROL;
    logic        clock, reset, avs_read, avs_write, avs_waitrequest, timer_irq;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [2:0]  fire_r, capture_event;
    logic [15:0] v, w, e;
    logic [7:0]  q;
    int          n_fail, cmp_count;
    int          ratio [8] = '{1, 4, 16, 32, 64, 128, 256, 512};

    rct16_cap_src i_rct16_cap_src (.clock(clock), .reset(reset), .fire(fire_r),
                                   .capture_event(capture_event));
    rct16_timer i_rct16_timer (.clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .capture_event(capture_event), .timer_irq(timer_irq));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] rdq);
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr_en;
        avs_write <= wr_en;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00, 4'h1, q);
        chk($sformatf("reg_%h", idx), {8'h0, q}, {8'h0, ex});
    endtask : rd

    // Count bytes only touched with the timer stopped
    task automatic setc(input logic [15:0] d);
        wr(CL, d[7:0]);
        wr(CH, d[15:8]);
    endtask : setc

    task automatic getc(output logic [15:0] d);
        bus(1'b0, CL, 8'h00, 4'h1, d[7:0]);
        bus(1'b0, CH, 8'h00, 4'h1, d[15:8]);
    endtask : getc

    task automatic fire(input logic [2:0] m);
        @(posedge clock);
        fire_r <= m;
        @(posedge clock);
        fire_r <= 3'h0;
        repeat (3) @(posedge clock);
    endtask : fire

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        give_verdict;
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        fire_r = 3'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rd(CTL + 8'(i), 8'h00);
        rd(8'h40, 8'h00);
        wr(RL, 8'h5a);
        bus(1'b1, RL, 8'ha5, 4'h0, q);
        rd(RL, 8'h5a);
        for (int k = 0; k < 8; k++) begin
            wr(MD, {1'b0, 3'(k), 4'h0});
            setc(16'h0000);
            wr(CTL, 8'h04);
            repeat (1022) @(posedge clock);
            wr(CTL, 8'h00);
            getc(v);
            // Run stands for 1025 edges; one step per full divide period
            e = 16'(1025 / ratio[k]);
            chk("divided_count", v, e);
            repeat (20) @(posedge clock);
            getc(w);
            chk("held_count", w, v);
        end
        wr(MD, 8'h00);
        setc(16'hfff0);
        wr(CTL, 8'h04);
        repeat (30) @(posedge clock);
        rd(CTL, 8'h84);
        wr(CTL, 8'h80);
        getc(v);
        chk("wrapped_high", {8'h0, v[15:8]}, 16'h0000);
        repeat (50) @(posedge clock);
        rd(CTL, 8'h80);
        wr(IE, 8'h01);
        repeat (3) @(posedge clock);
        chk("irq_masked", 16'(timer_irq), 16'h0000);
        wr(IE, 8'h03);
        repeat (3) @(posedge clock);
        chk("irq_on", 16'(timer_irq), 16'h0001);
        wr(CTL, 8'h00);
        repeat (3) @(posedge clock);
        chk("irq_cleared", 16'(timer_irq), 16'h0000);
        wr(IE, 8'h00);
        wr(MD, 8'h80);
        wr(RL, 8'h00);
        wr(RH, 8'h80);
        setc(16'hfff0);
        wr(CTL, 8'h04);
        repeat (30) @(posedge clock);
        wr(CTL, 8'h80);
        getc(v);
        chk("reload_high", {8'h0, v[15:8]}, 16'h0080);
        wr(CTL, 8'h00);
        wr(MD, 8'h00);
        wr(CC, 8'h70);
        for (int c = 0; c < 3; c++) begin
            setc(16'h5a30 + 16'(c));
            fire(3'(1 << c));
            rd(CB + 8'(2 * c), 8'h30 + 8'(c));
            rd(CB + 8'(2 * c + 1), 8'h5a);
        end
        rd(CC, 8'h77);
        wr(CC, 8'h00);
        setc(16'h1111);
        fire(3'h1);
        rd(CB, 8'h30);
        wr(RL, 8'h00);
        wr(RH, 8'h44);
        for (int t = 1; t < 4; t++) begin
            wr(CC, 8'h70);
            wr(MD, 8'h80 | 8'(t));
            setc(16'h0300);
            fire(3'(1 << (t % 3)));
            getc(v);
            chk("other_channel", v, 16'h0300);
            fire(3'(1 << (t - 1)));
            getc(v);
            chk("trigger_reload", v, 16'h4400);
        end
        wr(MD, 8'h89);
        setc(16'h0300);
        fire(3'h1);
        getc(v);
        chk("capture_clear", v, 16'h0000);
        rd(CB + 8'h1, 8'h03);
        wr(CTL, 8'h01);
        wr(MD, 8'h08);
        setc(16'h0300);
        fire(3'h1);
        getc(v);
        chk("cmp_no_capclr", v, 16'h0300);
        wr(RL, 8'h10);
        wr(RH, 8'h00);
        wr(MD, 8'h04);
        setc(16'h0000);
        wr(CTL, 8'h05);
        repeat (100) @(posedge clock);
        rd(CTL, 8'h85);
        wr(CTL, 8'h81);
        getc(v);
        chk("match_cleared", 16'(v <= 16'h0010), 16'h0001);
        wr(MD, 8'h00);
        setc(16'h0000);
        wr(CTL, 8'h05);
        repeat (100) @(posedge clock);
        wr(CTL, 8'h81);
        getc(v);
        chk("match_passed", 16'(v > 16'h0010), 16'h0001);
        wr(CTL, 8'h00);
        setc(16'h0000);
        wr(CTL, 8'h04);
        repeat (100) @(posedge clock);
        rd(CTL, 8'h04);
        give_verdict;
    end
endmodule : rct16_timer_tb
